// >>> rtl/list_ptr_map.vh
`ifndef LIST_PTR_MAP_VH
`define LIST_PTR_MAP_VH

// byte offsets of the pointer registers (8-bit register port)
`define OFF_CMD_BASE_HIGH 8'h1D
`define OFF_CMD_BASE_MID 8'h1E
`define OFF_CMD_BASE_LOW 8'h1F
`define OFF_RESULT_INDEX 8'h20
`define OFF_RES_BASE_HIGH 8'h21
`define OFF_RES_BASE_MID 8'h22
`define OFF_RES_BASE_LOW 8'h23
`define OFF_LIST0_OFFSET 8'h24
`define OFF_LIST1_OFFSET 8'h25
`define OFF_CMD_INDEX 8'h1C
`define OFF_CONTROL 8'h26

// field positions
`define CTRL_ENABLE_BIT 0
`define CTRL_SPECIAL_BIT 1
`define CTRL_LIST_SEL_BIT 2
`define OFFSET_FIELD_W 7
`define CMD_BASE_W 24
`define RES_BASE_W 20

// field masks; bits outside a pointer field are never stored
`define BASE_LOW_MASK 8'hFC
`define RES_HIGH_MASK 8'h0F

// reset values
`define RST_BYTE 8'h00
`define RST_OFFSET 7'h00
`define RST_CONTROL 8'h00

// entry sizes as address shift (16-bit result, 32-bit command)
`define RES_ENTRY_SHIFT 1
`define CMD_ENTRY_SHIFT 2

`endif

// >>> rtl/ptr_byte_bank.v
`timescale 1ns/1ps
`include "list_ptr_map.vh"

// small byte store with registered read data, one lane per entry
module ptr_byte_bank #(
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire we_i,
    input wire [AW-1:0] waddr_i,
    input wire [7:0] wdata_i,
    input wire [AW-1:0] raddr_i,
    output reg [7:0] rdata_o,
    output wire [8*DEPTH-1:0] flat_o
);

    reg [7:0] mem_reg [0:DEPTH-1];
    genvar g;

    ////////////////////////////////////////////////////////////////
    // one register per byte; flat view feeds the address adders
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : gen_byte
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    mem_reg[g] <= `RST_BYTE;
                end else if (we_i && waddr_i == g) begin
                    mem_reg[g] <= wdata_i;
                end
            end
            assign flat_o[8*g +: 8] = mem_reg[g];
        end
    endgenerate

    // registered read port
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= `RST_BYTE;
        end else begin
            rdata_o <= mem_reg[raddr_i];
        end
    end

endmodule

// >>> rtl/list_address_pointers.v
// Behaviour
// R1 - command base bits 23:2 address both command lists
// R2 - base writes only when disabled or special access
// R3 - result index read-only, counts 16-bit entries
// R4 - result base bits 19:2 address result lists
// R5 - list 0 offset fixed zero, 7 bits
// R6 - list 1 offset writable only when permitted
// R7 - list 1 offset added to both bases
// R8 - offsets count entries, not bytes
// R9 - address is base plus offset plus index
// R10 - list select bit picks offset into sum
// R11 - command index read-only, device advanced
// R12 - base pointer low two bits read zero
// R13 - software changes pointers only while disabled; the code also takes pointer writes while enabled if special access is set
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "list_ptr_map.vh"

module list_address_pointers #(
    parameter IDX_W = 8
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire cmd_advance_i,
    input wire cmd_restart_i,
    input wire res_store_i,
    input wire res_restart_i,
    input wire list_swap_i,
    output reg [23:0] cmd_fetch_addr_o,
    output reg [19:0] res_store_addr_o,
    output reg active_list_select_o
);

    ////////////////////////////////////////////////////////////////
    // control register: enable, special access, list select
    reg converter_enable_reg;
    reg special_access_bit_reg;
    reg active_list_select_reg;
    reg [6:0] list1_offset_field_reg;
    reg [IDX_W-1:0] command_entry_index_reg;
    reg [IDX_W-1:0] result_index_reg;
    reg [7:0] rdata_next;
    reg rd_bank_reg;
    reg rd_cmd_bank_reg;
    wire write_allowed;
    wire cmd_we;
    wire res_we;
    wire [7:0] cmd_rdata;
    wire [7:0] res_rdata;
    wire [31:0] cmd_flat;
    wire [31:0] res_flat;
    wire [23:0] command_base_field;
    wire [19:0] result_base_field;
    wire [6:0] list0_offset_field;
    wire [6:0] active_offset;
    wire cmd_sel;
    wire res_sel;
    wire ctrl_we;
    wire list1_we;
    wire [1:0] bank_addr;
    reg [7:0] bank_wdata;
    reg [7:0] rdata_reg;
    wire [23:0] cmd_offset_term;
    wire [23:0] cmd_index_term;
    wire [19:0] res_offset_term;
    wire [19:0] res_index_term;
    wire [23:0] cmd_fetch_next;
    wire [19:0] res_store_next;

    // pointer writes gated while the converter runs
    assign write_allowed = ~converter_enable_reg | special_access_bit_reg; // see R2

    // address decode; each base pointer spans three byte addresses
    assign cmd_sel = (addr_i == `OFF_CMD_BASE_HIGH) || (addr_i == `OFF_CMD_BASE_MID)
        || (addr_i == `OFF_CMD_BASE_LOW);
    assign res_sel = (addr_i == `OFF_RES_BASE_HIGH) || (addr_i == `OFF_RES_BASE_MID)
        || (addr_i == `OFF_RES_BASE_LOW);
    assign ctrl_we = wr_i && (addr_i == `OFF_CONTROL);
    assign list1_we = wr_i && (addr_i == `OFF_LIST1_OFFSET) && write_allowed; // see R6

    // a write to a locked pointer byte is dropped, not held for later
    assign cmd_we = wr_i && write_allowed && cmd_sel; // see R2
    assign res_we = wr_i && write_allowed && res_sel; // see R2

    // high byte sits at the lowest address, so bank slot 0 is the high byte
    assign bank_addr = addr_i[1:0] - 2'h1;

    ////////////////////////////////////////////////////////////////
    // bits outside each field are dropped on the way in, so reads show zeros
    always @* begin
        bank_wdata = wdata_i;
        case (addr_i)
            `OFF_CMD_BASE_LOW: bank_wdata = wdata_i & `BASE_LOW_MASK; // see R12
            `OFF_RES_BASE_LOW: bank_wdata = wdata_i & `BASE_LOW_MASK; // see R12
            `OFF_RES_BASE_HIGH: bank_wdata = wdata_i & `RES_HIGH_MASK; // see R4
            default: bank_wdata = wdata_i;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // byte stores for the two base pointers; index 0 holds high byte
    ptr_byte_bank #(.DEPTH(4), .AW(2)) u_cmd_bank (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(cmd_we),
        .waddr_i(bank_addr),
        .wdata_i(bank_wdata),
        .raddr_i(bank_addr),
        .rdata_o(cmd_rdata),
        .flat_o(cmd_flat)
    );

    ptr_byte_bank #(.DEPTH(4), .AW(2)) u_res_bank (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(res_we),
        .waddr_i(bank_addr),
        .wdata_i(bank_wdata),
        .raddr_i(bank_addr),
        .rdata_o(res_rdata),
        .flat_o(res_flat)
    );

    // assemble fields; low two bits forced to zero for word alignment
    assign command_base_field = {cmd_flat[7:0], cmd_flat[15:8], cmd_flat[23:18], 2'h0}; // see R1
    assign result_base_field = {res_flat[3:0], res_flat[15:8], res_flat[23:18], 2'h0}; // see R4

    assign list0_offset_field = `RST_OFFSET; // see R5
    // list 1 offset feeds both sums while list 1 is active
    assign active_offset = active_list_select_reg ? list1_offset_field_reg // see R7
        : list0_offset_field; // see R10

    ////////////////////////////////////////////////////////////////
    // control register: enable and special access
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            converter_enable_reg <= 1'b0;
            special_access_bit_reg <= 1'b0;
        end else if (ctrl_we) begin
            converter_enable_reg <= wdata_i[`CTRL_ENABLE_BIT];
            special_access_bit_reg <= wdata_i[`CTRL_SPECIAL_BIT];
        end
    end

    // list-1 offset keeps its value whenever the pointers are locked
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            list1_offset_field_reg <= `RST_OFFSET;
        end else if (list1_we) begin
            list1_offset_field_reg <= wdata_i[6:0]; // see R6
        end
    end

    // active list: software may pick it only while disabled; hardware swaps
    // a swap beats a software write in the same cycle, the sequencer owns it
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_list_select_reg <= 1'b0;
        end else if (list_swap_i) begin
            active_list_select_reg <= ~active_list_select_reg; // see R10
        end else if (ctrl_we && !converter_enable_reg) begin
            active_list_select_reg <= wdata_i[`CTRL_LIST_SEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // command index: advanced by the sequencer only, software cannot write it
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            command_entry_index_reg <= {IDX_W{1'b0}};
        end else if (cmd_restart_i) begin
            command_entry_index_reg <= {IDX_W{1'b0}}; // see R11
        end else if (cmd_advance_i) begin
            command_entry_index_reg <= command_entry_index_reg + 1'b1; // see R11
        end
    end

    // result index: a restart beats a store, so a new list starts at entry zero
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_index_reg <= {IDX_W{1'b0}};
        end else if (res_restart_i) begin
            result_index_reg <= {IDX_W{1'b0}}; // see R3
        end else if (res_store_i) begin
            result_index_reg <= result_index_reg + 1'b1; // see R3
        end
    end

    ////////////////////////////////////////////////////////////////
    // offsets and indices count entries; scale them to byte addresses
    assign cmd_offset_term = {17'h00000, active_offset} << `CMD_ENTRY_SHIFT; // see R8
    assign cmd_index_term = {{(24-IDX_W){1'b0}}, command_entry_index_reg} << `CMD_ENTRY_SHIFT;
    assign res_offset_term = {13'h0000, active_offset} << `RES_ENTRY_SHIFT; // see R8
    assign res_index_term = {{(20-IDX_W){1'b0}}, result_index_reg} << `RES_ENTRY_SHIFT;

    // sums wrap inside the field; keeping lists clear of the top is up to software
    assign cmd_fetch_next = command_base_field + cmd_offset_term + cmd_index_term; // see R9
    assign res_store_next = result_base_field + res_offset_term + res_index_term; // see R9

    // registered so the memory side sees a steady address
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_fetch_addr_o <= 24'h000000;
            res_store_addr_o <= 20'h00000;
            active_list_select_o <= 1'b0;
        end else begin
            cmd_fetch_addr_o <= cmd_fetch_next;
            res_store_addr_o <= res_store_next;
            active_list_select_o <= active_list_select_reg; // see R10
        end
    end

    ////////////////////////////////////////////////////////////////
    // read mux; bank reads are already registered, others registered here
    always @* begin
        rdata_next = 8'h00;
        case (addr_i)
            `OFF_CMD_INDEX: rdata_next = command_entry_index_reg[7:0];
            `OFF_RESULT_INDEX: rdata_next = result_index_reg[7:0];
            `OFF_LIST0_OFFSET: rdata_next = {1'b0, list0_offset_field};
            `OFF_LIST1_OFFSET: rdata_next = {1'b0, list1_offset_field_reg};
            `OFF_CONTROL: rdata_next = {5'h00, active_list_select_reg,
                special_access_bit_reg, converter_enable_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    // remember which source answers; a cycle with no strobe leaves zero behind
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_bank_reg <= 1'b0;
            rd_cmd_bank_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            rd_cmd_bank_reg <= rd_i && cmd_sel;
            rd_bank_reg <= rd_i && res_sel;
            rdata_reg <= rd_i ? rdata_next : 8'h00;
        end
    end

    // select among flops only; the banks also answer one cycle after the strobe
    always @* begin
        if (rd_cmd_bank_reg) begin
            rdata_o = cmd_rdata;
        end else if (rd_bank_reg) begin
            rdata_o = res_rdata;
        end else begin
            rdata_o = rdata_reg;
        end
    end

endmodule

// >>> sim/list_ptr_checker.sv
`timescale 1ns/1ps
module list_ptr_checker (
    input wire clk_i,
    input wire rst_n_i,
    input wire [7:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire cmd_advance_i,
    input wire cmd_restart_i,
    input wire res_store_i,
    input wire res_restart_i,
    input wire list_swap_i,
    input wire [23:0] cmd_fetch_addr_o,
    input wire [19:0] res_store_addr_o,
    input wire active_list_select_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // no write and no index event; with no swap as well, nothing may move the addresses
    wire quiet = !wr_i && !cmd_advance_i && !cmd_restart_i && !res_store_i && !res_restart_i;
    ////////////////////////////////////////////////////////////////
    a_list0_zero: assert property (rd_i && addr_i == 8'h24 |=> rdata_o == 8'h00)
        else $error("list 0 offset read back nonzero");
    a_cmd_aligned: assert property (rd_i && addr_i == 8'h1F |=> rdata_o[1:0] == 2'h0)
        else $error("command base low bits not zero");
    a_res_aligned: assert property (rd_i && addr_i == 8'h23 |=> rdata_o[1:0] == 2'h0)
        else $error("result base low bits not zero");
    a_res_width: assert property (rd_i && addr_i == 8'h21 |=> rdata_o[7:4] == 4'h0)
        else $error("result base wider than its field");
    a_fetch_word: assert property (cmd_fetch_addr_o[1:0] == 2'h0)
        else $error("command fetch address not word aligned");
    a_store_half: assert property (res_store_addr_o[0] == 1'b0)
        else $error("result store address odd");
    a_addr_hold: assert property ((quiet && !list_swap_i)[*3] |=> $stable(cmd_fetch_addr_o)
        && $stable(res_store_addr_o))
        else $error("address moved with no cause");
    a_sel_hold: assert property ((!list_swap_i && !wr_i)[*2] |=> $stable(active_list_select_o))
        else $error("list select moved with no swap");
    c_swap: cover property (list_swap_i ##2 active_list_select_o);
    c_adv: cover property (cmd_advance_i);
    c_store: cover property (res_store_i);
endmodule

// >>> sim/list_mem_model.sv
`timescale 1ns/1ps
// memory side: each step fetches a command, waits GAP cycles, stores its result
module list_mem_model #(
    parameter GAP = 2
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire start_i,
    input wire [3:0] steps_i,
    output reg cmd_advance_o,
    output reg res_store_o,
    output wire busy_o
);
    reg [3:0] left_reg;
    reg [3:0] wait_reg;
    assign busy_o = left_reg != 4'h0;
    // slow answer on purpose so an advance and its store never land back to back
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_reg <= 4'h0;
            wait_reg <= 4'h0;
            cmd_advance_o <= 1'b0;
            res_store_o <= 1'b0;
        end else begin
            cmd_advance_o <= 1'b0;
            res_store_o <= 1'b0;
            if (start_i) begin
                left_reg <= steps_i;
            end else if (left_reg != 4'h0) begin
                if (wait_reg == 4'h0) begin
                    cmd_advance_o <= 1'b1;
                    wait_reg <= 4'(GAP);
                end else if (wait_reg == 4'h1) begin
                    res_store_o <= 1'b1;
                    wait_reg <= 4'h0;
                    left_reg <= left_reg - 4'h1;
                end else begin
                    wait_reg <= wait_reg - 4'h1;
                end
            end
        end
    end
endmodule

// >>> sim/tb_list_address_pointers.sv
`timescale 1ns/1ps
module tb_list_address_pointers;
    reg clk_i, rst_n_i, wr_i, rd_i, cmd_restart_i, res_restart_i, list_swap_i, start;
    reg [7:0] addr_i, wdata_i;
    reg [3:0] steps;
    wire [7:0] rdata_o;
    wire [23:0] cmd_fetch_addr_o;
    wire [19:0] res_store_addr_o;
    wire active_list_select_o, cmd_advance_i, res_store_i, busy;
    int n_errors = 0, n_checks = 0, i;
    list_address_pointers u_list_address_pointers (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cmd_advance_i(cmd_advance_i), .cmd_restart_i(cmd_restart_i),
        .res_store_i(res_store_i), .res_restart_i(res_restart_i), .list_swap_i(list_swap_i),
        .cmd_fetch_addr_o(cmd_fetch_addr_o), .res_store_addr_o(res_store_addr_o),
        .active_list_select_o(active_list_select_o));
    list_mem_model u_list_mem_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start),
        .steps_i(steps), .cmd_advance_o(cmd_advance_i), .res_store_o(res_store_i),
        .busy_o(busy));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input [7:0] a, input [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", {16'h0, rdata_o}, {16'h0, e});
    endtask
    task automatic ca(input [23:0] c, input [19:0] r, input s);
        repeat (3) @(posedge clk_i);
        #1 chk("cmd_addr", cmd_fetch_addr_o, c);
        chk("res_addr", {4'h0, res_store_addr_o}, {4'h0, r});
        chk("sel", {23'h0, active_list_select_o}, {23'h0, s});
    endtask
    task automatic swap;
        @(posedge clk_i);
        list_swap_i <= 1'b1;
        @(posedge clk_i);
        list_swap_i <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rdc(8'h24, 8'h00);
        wr(8'h1D, 8'h12);
        wr(8'h1E, 8'h34);
        wr(8'h1F, 8'h57);
        wr(8'h21, 8'hFA);
        wr(8'h22, 8'hBC);
        wr(8'h23, 8'hDF);
        wr(8'h25, 8'h05);
        wr(8'h24, 8'hFF);
        wr(8'h20, 8'h33);
        rdc(8'h1F, 8'h54);
        rdc(8'h23, 8'hDC);
        rdc(8'h1D, 8'h12);
        rdc(8'h21, 8'h0A);
        rdc(8'h25, 8'h05);
        rdc(8'h24, 8'h00);
        rdc(8'h20, 8'h00);
        ca(24'h123454, 20'hABCDC, 1'b0);
        wr(8'h26, 8'h04);
        rdc(8'h26, 8'h04);
        ca(24'h123468, 20'hABCE6, 1'b1);
    endtask
    // enabled: pointer writes ignored unless special access is on
    task automatic t_lock;
        wr(8'h26, 8'h01);
        wr(8'h1F, 8'h00);
        wr(8'h21, 8'h03);
        wr(8'h25, 8'h07);
        rdc(8'h1F, 8'h54);
        rdc(8'h21, 8'h0A);
        rdc(8'h25, 8'h05);
        wr(8'h26, 8'h03);
        wr(8'h1F, 8'h5B);
        rdc(8'h1F, 8'h58);
        wr(8'h1F, 8'h57);
        wr(8'h25, 8'h07);
        rdc(8'h25, 8'h07);
        wr(8'h25, 8'h05);
        wr(8'h26, 8'h01);
    endtask
    // list 1 offset counts 32-bit commands and 16-bit results
    task automatic t_lists;
        swap();
        ca(24'h123468, 20'hABCE6, 1'b1);
        @(posedge clk_i);
        start <= 1'b1;
        steps <= 4'h3;
        @(posedge clk_i);
        start <= 1'b0;
        #1;
        for (i = 0; i < 100 && busy !== 1'b0; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk("busy", {23'h0, busy}, 24'h0);
        ca(24'h123474, 20'hABCEC, 1'b1);
        rdc(8'h1C, 8'h03);
        rdc(8'h20, 8'h03);
        @(posedge clk_i);
        cmd_restart_i <= 1'b1;
        res_restart_i <= 1'b1;
        @(posedge clk_i);
        cmd_restart_i <= 1'b0;
        res_restart_i <= 1'b0;
        swap();
        ca(24'h123454, 20'hABCDC, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // watchdog far beyond the roughly 110 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        report_and_stop();
    end
    initial begin
        {rst_n_i, wr_i, rd_i, cmd_restart_i, res_restart_i, list_swap_i, start} = 7'h00;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        steps = 4'h0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_lock();
        t_lists();
        report_and_stop();
    end
endmodule
bind list_address_pointers list_ptr_checker u_list_ptr_checker (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cmd_advance_i(cmd_advance_i), .cmd_restart_i(cmd_restart_i), .res_store_i(res_store_i),
    .res_restart_i(res_restart_i), .list_swap_i(list_swap_i),
    .cmd_fetch_addr_o(cmd_fetch_addr_o), .res_store_addr_o(res_store_addr_o),
    .active_list_select_o(active_list_select_o));
